// ==== include/sbi_pkg.sv ====
// constants and types of the burst sram bus interface
`default_nettype none

package sbi_pkg;

  localparam int unsigned ADDR_W  = 17;
  localparam int unsigned DATA_W  = 36;
  localparam int unsigned LANES   = 4;
  localparam int unsigned BEAT_W  = 2;

  // values after reset, and the one-beat step
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
  localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 2'h1;
  localparam logic [1:0]        SYNC_RST = 2'h0;

  typedef enum logic [1:0] {
    SBI_IDLE  = 2'b01,
    SBI_BURST = 2'b10
  } sbi_state_t;

endpackage : sbi_pkg

`default_nettype wire

// ==== hdl/sbi_core.sv ====
// pin-level logic of the burst synchronous static memory
`timescale 1ns/1ps
`default_nettype none

module sbi_core #(
  parameter int unsigned ADDR_W = sbi_pkg::ADDR_W,
  parameter int unsigned DATA_W = sbi_pkg::DATA_W,
  parameter int unsigned LANES  = sbi_pkg::LANES
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,

  // address and selects
  input  wire logic [ADDR_W-1:0] word_address_bus,
  input  wire logic              master_chip_select_n,
  input  wire logic              chip_select_high,
  input  wire logic              chip_select_low_n,

  // strobes and advance
  input  wire logic              processor_addr_strobe_n,
  input  wire logic              controller_addr_strobe_n,
  input  wire logic              burst_advance_n,

  // write enables
  input  wire logic              write_all_bytes_n,
  input  wire logic              lane_write_gate_n,
  input  wire logic [LANES-1:0]  lane_write_n,

  // static and asynchronous controls
  input  wire logic              output_enable_n,
  input  wire logic              burst_order_select,
  input  wire logic              single_stage_select_n,
  input  wire logic              sleep_request,

  // data pins, split into three signals
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe,

  // status
  output logic                   burst_active,
  output logic                   sleep_active
);

  localparam int unsigned LANE_W = DATA_W / LANES;
  localparam int unsigned BW     = sbi_pkg::BEAT_W;

  ////////////////////////////////////////////////////////////////////////////
  // storage: one array per lane, read word gathered here

  logic [DATA_W-1:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] sleep_sync_q;
  logic [1:0] sleep_sync_d;
  logic [1:0] order_sync_q;
  logic [1:0] order_sync_d;
  logic [1:0] stage_sync_q;
  logic [1:0] stage_sync_d;
  logic       sleep_q;
  logic       order_q;
  logic       stage_n_q;

  // sleep, order and stage select pins pass two flops; output enable does not
  // static selects may only move between bursts
  // limitation: linear order and flow mode for two edges after reset
  always_comb begin
    sleep_sync_d = {sleep_sync_q[0], sleep_request};
    order_sync_d = {order_sync_q[0], burst_order_select};
    stage_sync_d = {stage_sync_q[0], single_stage_select_n};
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sleep_sync_q <= sbi_pkg::SYNC_RST;
      order_sync_q <= sbi_pkg::SYNC_RST;
      stage_sync_q <= sbi_pkg::SYNC_RST;
    end else begin
      sleep_sync_q <= sleep_sync_d;
      order_sync_q <= order_sync_d;
      stage_sync_q <= stage_sync_d;
    end
  end

  assign sleep_q   = sleep_sync_q[1];
  assign order_q   = order_sync_q[1];
  assign stage_n_q = stage_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // cycle decode

  sbi_pkg::sbi_state_t state_q;
  sbi_pkg::sbi_state_t state_d;

  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] base_d;
  logic [BW-1:0]     beat_q;
  logic [BW-1:0]     beat_d;

  logic              all_sel;
  logic              psel_start;
  logic              csel_start;
  logic              start;
  logic              deselect;
  logic              cont;
  logic              step;
  logic [LANES-1:0]  lane_en;
  logic              is_write;
  logic              do_write;
  logic              do_read;
  logic [ADDR_W-1:0] cyc_addr;
  logic [BW-1:0]     low_bits;
  logic [BW-1:0]     cyc_beat;

  always_comb begin
    all_sel = ~master_chip_select_n & chip_select_high & ~chip_select_low_n;

    psel_start = ~processor_addr_strobe_n & ~master_chip_select_n;
    // controller start needs processor strobe quiet or master select high
    csel_start = ~csel_blocked() & ~controller_addr_strobe_n;

    start    = (psel_start | csel_start) & all_sel;
    deselect = (psel_start | csel_start) & ~all_sel;
    cont     = ~psel_start & ~csel_start & (state_q == sbi_pkg::SBI_BURST);

    // advance not sampled on a start or deselect edge
    step = cont & ~burst_advance_n;

    if (!write_all_bytes_n) begin
      lane_en = {LANES{1'b1}};
    end else if (!lane_write_gate_n) begin
      lane_en = ~lane_write_n;
    end else begin
      lane_en = '0;
    end
    // no active lane is a read
    is_write = |lane_en;

    // controller start takes writes on its own edge
    do_write = ((csel_start & start) | cont) & is_write;
    do_read  = start & (psel_start | ~is_write) | (cont & ~is_write);

    // four beat counter wraps in the group
    cyc_beat = step ? beat_q + sbi_pkg::BEAT_ONE : beat_q;

    // order select picks interleaved or linear
    if (order_q) begin
      low_bits = base_q[BW-1:0] ^ cyc_beat;
    end else begin
      low_bits = base_q[BW-1:0] + cyc_beat;
    end

    // external address only on a valid start
    if (start) begin
      cyc_addr = word_address_bus;
    end else begin
      cyc_addr = {base_q[ADDR_W-1:BW], low_bits};
    end
  end

  // blocked processor strobe does not stop a controller start
  function automatic logic csel_blocked();
    csel_blocked = ~processor_addr_strobe_n & ~master_chip_select_n;
  endfunction : csel_blocked

  ////////////////////////////////////////////////////////////////////////////
  // burst state

  always_comb begin
    state_d = state_q;
    base_d  = base_q;
    beat_d  = beat_q;
    // sleep freezes the controller, contents kept
    if (!sleep_q) begin
      if (start) begin
        state_d = sbi_pkg::SBI_BURST;
        base_d  = word_address_bus;
        beat_d  = sbi_pkg::BEAT_RST;
      end else if (deselect) begin
        state_d = sbi_pkg::SBI_IDLE;
      end else if (cont) begin
        beat_d = cyc_beat;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= sbi_pkg::SBI_IDLE;
      base_q  <= sbi_pkg::ADDR_RST;
      beat_q  <= sbi_pkg::BEAT_RST;
    end else begin
      state_q <= state_d;
      base_q  <= base_d;
      beat_q  <= beat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array write, one lane per loop pass

  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl = gl + 1) begin : g_lane
      // one array per lane keeps each array to a single writer
      logic [LANE_W-1:0] lane_mem [0:(1<<ADDR_W)-1];
      // data and enables taken on the clock edge
      always_ff @(posedge clk_sys) begin
        if (!sleep_q && do_write && lane_en[gl]) begin
          lane_mem[cyc_addr] <= dq_in[gl*LANE_W +: LANE_W];
        end
      end
      // array read sees the old word on a same-edge write
      assign rd_word[gl*LANE_W +: LANE_W] = lane_mem[cyc_addr];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read pipeline

  logic [DATA_W-1:0] pipe_q;
  logic [DATA_W-1:0] pipe_d;
  logic              pipe_vld_q;
  logic              pipe_vld_d;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] dout_d;
  logic              dout_vld_q;
  logic              dout_vld_d;
  logic              act_q;
  logic              act_d;
  logic              slp_q;
  logic              slp_d;

  always_comb begin
    pipe_d     = pipe_q;
    pipe_vld_d = pipe_vld_q;
    dout_d     = dout_q;
    dout_vld_d = dout_vld_q;
    act_d      = (state_d == sbi_pkg::SBI_BURST);
    slp_d      = sleep_q;
    if (!sleep_q) begin
      pipe_d     = rd_word;
      pipe_vld_d = do_read;
      if (!stage_n_q) begin
        // single stage: word straight to output register
        dout_d     = rd_word;
        dout_vld_d = do_read;
      end else begin
        // pipelined: one more edge after capture
        dout_d     = pipe_q;
        dout_vld_d = pipe_vld_q;
      end
      // a write cycle turns the drivers off
      if (do_write) begin
        dout_vld_d = 1'b0;
        pipe_vld_d = 1'b0;
      end
      if (deselect) begin
        pipe_vld_d = 1'b0;
      end
    end else begin
      dout_vld_d = 1'b0;
      pipe_vld_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pipe_q     <= '0;
      pipe_vld_q <= 1'b0;
      dout_q     <= '0;
      dout_vld_q <= 1'b0;
      act_q      <= 1'b0;
      slp_q      <= 1'b0;
    end else begin
      pipe_q     <= pipe_d;
      pipe_vld_q <= pipe_vld_d;
      dout_q     <= dout_d;
      dout_vld_q <= dout_vld_d;
      act_q      <= act_d;
      slp_q      <= slp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  assign dq_out       = dout_q;
  assign burst_active = act_q;
  assign sleep_active = slp_q;

  // enable is combinational: the pin must follow
  // output enable without waiting for a clock edge
  assign dq_oe = dout_vld_q & ~output_enable_n;

endmodule : sbi_core

`default_nettype wire

// ==== verif/sbi_monitor.sv ====
// pin behaviour checker for the burst sram core
`timescale 1ns/1ps
`default_nettype none
module sbi_monitor #(
  parameter int unsigned LANES = 4
) (
  // clock, reset
  input wire logic             clk_sys,
  input wire logic             reset_n,
  // bus
  input wire logic             master_chip_select_n,
  input wire logic             chip_select_high,
  input wire logic             chip_select_low_n,
  input wire logic             processor_addr_strobe_n,
  input wire logic             controller_addr_strobe_n,
  input wire logic             write_all_bytes_n,
  input wire logic             lane_write_gate_n,
  input wire logic [LANES-1:0] lane_write_n,
  // async, static
  input wire logic             output_enable_n,
  input wire logic             single_stage_select_n,
  input wire logic             sleep_request,
  // outputs
  input wire logic             dq_oe,
  input wire logic             burst_active,
  input wire logic             sleep_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic sel_ok, p_go, go, wr, rd, idle;
  assign sel_ok = !master_chip_select_n && chip_select_high && !chip_select_low_n;
  assign p_go = !processor_addr_strobe_n && !master_chip_select_n;
  assign go = (p_go || !controller_addr_strobe_n) && !sleep_active;
  assign wr = !write_all_bytes_n || (!lane_write_gate_n && !(&lane_write_n));
  assign rd = go && sel_ok && (p_go || !wr);
  assign idle = processor_addr_strobe_n && controller_addr_strobe_n;
  oe_gate_a:
    assert property (dq_oe |-> !output_enable_n && (burst_active || $past(burst_active)))
    else $error("dq_oe outside a selected read");
  pipe_read_a:
    assert property (rd && single_stage_select_n ##1 idle |=> dq_oe == !output_enable_n)
    else $error("pipelined read not driven");
  flow_read_a:
    assert property (rd && !single_stage_select_n |=> dq_oe == !output_enable_n)
    else $error("flow read not driven");
  start_burst_a:
    assert property (go && sel_ok |=> burst_active) else $error("start not taken");
  deselect_a:
    assert property (go && !sel_ok ##1 idle |-> !burst_active ##1 !dq_oe)
    else $error("deselect ignored");
  proc_block_a:
    assert property (p_go == 1'b0 && !processor_addr_strobe_n && idle == 1'b0
      && controller_addr_strobe_n && !burst_active |=> !burst_active)
    else $error("blocked strobe started");
  write_start_a:
    assert property (go && sel_ok && !p_go && wr |=> !dq_oe) else $error("write drove bus");
  sleep_on_a:
    assert property ($rose(sleep_request) |-> ##[1:3] sleep_active) else $error("sleep late");
  sleep_quiet_a:
    assert property (sleep_active |-> !dq_oe) else $error("driving in sleep");
  cover property (rd ##3 dq_oe);
  cover property (go && sel_ok && wr);
  cover property (sleep_active);
endmodule : sbi_monitor
bind sbi_core sbi_monitor #(.LANES(LANES)) sbi_monitor_inst (.*);
`default_nettype wire

// ==== verif/sbi_host.sv ====
// bus master model driving the memory pins
`timescale 1ns/1ps
`default_nettype none
module sbi_host (
  // clock
  input  wire logic        clk_sys,
  // pins toward the memory
  output var  logic [16:0] word_address_bus,
  output var  logic        master_chip_select_n,
  output var  logic        chip_select_high,
  output var  logic        chip_select_low_n,
  output var  logic        processor_addr_strobe_n,
  output var  logic        controller_addr_strobe_n,
  output var  logic        burst_advance_n,
  output var  logic        write_all_bytes_n,
  output var  logic        lane_write_gate_n,
  output var  logic [3:0]  lane_write_n,
  output var  logic [35:0] dq_in
);
  initial begin
    {word_address_bus, dq_in} = '0;
    {master_chip_select_n, chip_select_high, chip_select_low_n} = 3'h2;
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
    {write_all_bytes_n, lane_write_gate_n, lane_write_n} = 6'h3F;
  end
  // one request per edge, held until the next edge samples it
  task automatic beat(input logic [2:0] s, input logic [2:0] pcv, input logic [5:0] w,
                      input logic [3:0] a, input logic [35:0] d);
    @(posedge clk_sys);
    {master_chip_select_n, chip_select_high, chip_select_low_n} <= s;
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} <= pcv;
    {write_all_bytes_n, lane_write_gate_n, lane_write_n} <= w;
    word_address_bus <= {13'h0000, a};
    // released lines show the inverse so stale data never matches
    dq_in <= (w[5] && (w[4] || &w[3:0])) ? ~dq_in : d;
  endtask : beat
endmodule : sbi_host
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench of the burst sram core
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic             clk_sys = 1'b0;
  logic             reset_n = 1'b0;
  logic             output_enable_n = 1'b1;
  logic             burst_order_select = 1'b1;
  logic             single_stage_select_n = 1'b1;
  logic             sleep_request = 1'b0;
  wire logic [16:0] word_address_bus;
  wire logic [35:0] dq_in, dq_out;
  wire logic [3:0]  lane_write_n;
  wire logic        master_chip_select_n, chip_select_high, chip_select_low_n;
  wire logic        processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
  wire logic        write_all_bytes_n, lane_write_gate_n, dq_oe, burst_active, sleep_active;
  int               num_errors = 0;
  int               checks_done = 0;
  int               seed = 32'h378999BE;
  logic [35:0]      mem [16];
  always #20 clk_sys = ~clk_sys;
  sbi_core sbi_core_inst (.*);
  sbi_host sbi_host_inst (.*);
  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  function automatic logic [3:0] at(input logic [3:0] a, input int k, input logic il);
    return {a[3:2], il ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
  endfunction : at
  // burst of n beats from base a; reads compared as they land
  task automatic run(input logic [3:0] a, input int n, input logic ps, input logic [5:0] w);
    logic il, ff, wr;
    logic [35:0] d;
    il = 1'($random(seed));
    ff = 1'($random(seed));
    wr = !ps && (!w[5] || (!w[4] && w[3:0] != 4'hF));
    // statics change on an edge, then pass the two-flop synchronisers
    sbi_host_inst.beat(3'h2, 3'h7, 6'h3F, a, 36'h0);
    burst_order_select <= il;
    single_stage_select_n <= ff;
    output_enable_n <= wr;
    sbi_host_inst.beat(3'h2, 3'h7, 6'h3F, a, 36'h0);
    for (int j = 0; j < n + 1 + ff; j++) begin
      d = {4'($random(seed)), 32'($random(seed))};
      if (j < n) begin
        // advance low on the start edge is ignored
        sbi_host_inst.beat(3'h2, {!ps || j > 0, ps || j > 0, 1'b0},
                           (j == 0 || !ps) ? w : 6'h3F, a, d);
        for (int i = 0; i < 4; i++) begin
          if (wr && (!w[5] || !w[i])) mem[at(a, j, il)][9*i+:9] = d[9*i+:9];
        end
      end else begin
        sbi_host_inst.beat(3'h2, 3'h7, 6'h3F, a, d);
      end
      #1;
      if (!wr && j >= 1 + ff) begin
        check(dq_out, mem[at(a, j - 1 - ff, il)]);
        check(36'(dq_oe), 36'h1);
      end
    end
  endtask : run
  task automatic report_and_stop();
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    check(36'({dq_oe, burst_active, sleep_active}), 36'h0);
    for (int b = 0; b < 16; b += 4) run(4'(b), 4, 1'b0, 6'h1F);
    repeat (60) run(4'($random(seed)), 1 + ($random(seed) & 3), 1'($random(seed)),
                    6'($random(seed)));
    // deselect, then a strobe blocked by the master select
    output_enable_n <= 1'b0;
    sbi_host_inst.beat(3'h0, 3'h5, 6'h3F, 4'h0, 36'h0);
    sbi_host_inst.beat(3'h2, 3'h7, 6'h3F, 4'h0, 36'h0);
    sbi_host_inst.beat(3'h6, 3'h3, 6'h3F, 4'h0, 36'h0);
    sbi_host_inst.beat(3'h2, 3'h7, 6'h3F, 4'h0, 36'h0);
    #1;
    check(36'({burst_active, dq_oe}), 36'h0);
    // sleep must block this write and keep the old word
    sleep_request <= 1'b1;
    repeat (4) sbi_host_inst.beat(3'h2, 3'h7, 6'h3F, 4'h0, 36'h0);
    #1;
    check(36'({sleep_active, dq_oe}), 36'h2);
    sbi_host_inst.beat(3'h2, 3'h5, 6'h1F, 4'h0, 36'h0);
    sleep_request <= 1'b0;
    repeat (4) sbi_host_inst.beat(3'h2, 3'h7, 6'h3F, 4'h0, 36'h0);
    run(4'h0, 1, 1'b0, 6'h3F);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
